// ---- pmva_host_model.sv ----
// pmva_host_model.sv: behavioural command host for the vout/alert bank
`default_nettype none
module pmva_host_model
   import pmva_pkg::*;
(
   input  wire logic       ref_clk,
   output var pmva_cmd_type cmdReq
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // command issue
   // ------------------------------------------------------------------
   // released fields are inverted so a stale command can never look valid
   initial cmdReq = '0;

   task automatic send(input logic wr, input logic [7:0] code,
                       input logic [15:0] data);
      @(negedge ref_clk);
      cmdReq = '{valid: 1'b1, write: wr, code: code, data: data};
      @(negedge ref_clk);
      cmdReq = '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
   endtask : send
endmodule : pmva_host_model
`default_nettype wire

// ---- pmva_limit_clamp.sv ----
// pmva_limit_clamp.sv: target plus trim, clamped to the max/min window
`default_nettype none
module pmva_limit_clamp
   import pmva_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [15:0] target,
   input  wire logic [15:0] trim,
   input  wire logic [15:0] limitMax,
   input  wire logic [15:0] limitMin,
   output logic      [15:0] refRequest,
   output logic             limitHit
);
   typedef struct packed {
      logic [15:0] req;
      logic        hit;
   } pmva_clamp_type;

   pmva_clamp_type state_reg;
   pmva_clamp_type state_next;
   logic signed [17:0] sum;

   always_comb begin
      state_next = state_reg;
      sum = 18'($signed({2'h0, target})) + 18'($signed(trim));
      if (sum > $signed({2'h0, limitMax})) begin
         state_next.req = limitMax;
         state_next.hit = 1'b1;
      end else if (sum < $signed({2'h0, limitMin})) begin
         state_next.req = limitMin;
         state_next.hit = 1'b1;
      end else begin
         state_next.req = sum[15:0];
         state_next.hit = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign refRequest = state_reg.req;
   assign limitHit   = state_reg.hit;
endmodule : pmva_limit_clamp
`default_nettype wire

// ---- pmva_pkg.sv ----
// pmva_pkg.sv: constants, types and helpers for the vout/alert-mask bank
`default_nettype none
package pmva_pkg;

   // -------------------------------------------------------------------
   // command codes and selector bytes
   // -------------------------------------------------------------------
   localparam logic [7:0] CMD_ALERT_MASK  = 8'h1B;
   localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
   localparam logic [7:0] CMD_VOUT_TARGET = 8'h21;
   localparam logic [7:0] SEL_MISC_GROUP  = 8'h7F;
   localparam logic [7:0] SEL_VENDOR_GRP  = 8'h80;

   // -------------------------------------------------------------------
   // alert mask layout
   // -------------------------------------------------------------------
   localparam logic [7:0] MASK_MISC_VALUE   = 8'h01;
   localparam logic [7:0] MASK_VENDOR_WR    = 8'hCE;
   localparam logic [7:0] MASK_VENDOR_RESET = 8'hCE;
   localparam int         POWER_ON_BIT      = 7;
   localparam int         SELF_COND_BIT     = 6;
   localparam int         RESET_EVENT_BIT   = 3;
   localparam int         CROSS_BUS_BIT     = 2;
   localparam int         SYNC_FAULT_BIT    = 1;
   localparam int         FIRST_ALERT_BIT   = 0;

   // -------------------------------------------------------------------
   // output voltage format layout
   // -------------------------------------------------------------------
   localparam int         FMT_REL_BIT     = 7;
   localparam int         FMT_MODE_MSB    = 6;
   localparam int         FMT_MODE_LSB    = 5;
   localparam int         FMT_EXP_MSB     = 4;
   localparam logic [1:0] FMT_MODE_LINEAR = 2'h0;
   localparam logic [7:0] FMT_WR_MASK     = 8'h9F;
   localparam logic [7:0] FMT_RESET       = 8'h14;
   localparam logic [4:0] EXP_COARSEST    = 5'h1C;
   localparam logic [4:0] EXP_FINEST      = 5'h14;
   localparam logic [15:0] TARGET_RESET   = 16'h0000;

   // -------------------------------------------------------------------
   // ramp timing
   // -------------------------------------------------------------------
   localparam int         CLK_PERIOD_NS    = 4;
   localparam int         RAMP_TICK_NS     = 1000;
   localparam logic [7:0] RAMP_TICK_CYCLES =
      8'(RAMP_TICK_NS / CLK_PERIOD_NS);

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } pmva_cmd_type;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] data;
   } pmva_rsp_type;

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic pmva_exp_ok(input logic [4:0] e);
      pmva_exp_ok = ($signed(e) <= $signed(EXP_COARSEST)) &&
                    ($signed(e) >= $signed(EXP_FINEST));
   endfunction : pmva_exp_ok

   // rescale a linear mantissa from one exponent to another
   function automatic logic [15:0] pmva_rescale(input logic [15:0] v,
                                                input logic [4:0]  oldE,
                                                input logic [4:0]  newE);
      logic signed [5:0] d;
      d = 6'($signed(oldE)) - 6'($signed(newE));
      if (d >= 6'sh00) begin
         pmva_rescale = v << d;
      end else begin
         pmva_rescale = v >> (-d);
      end
   endfunction : pmva_rescale

endpackage : pmva_pkg
`default_nettype wire

// ---- pmva_ramp.sv ----
// pmva_ramp.sv: slews the reference toward its request at a set rate
`default_nettype none
module pmva_ramp
   import pmva_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [15:0] request,
   input  wire logic [15:0] stepPerTick,
   output logic      [15:0] refOut
);
   typedef struct packed {
      logic [7:0]  tick;
      logic [15:0] level;
   } pmva_ramp_type;

   pmva_ramp_type state_reg;
   pmva_ramp_type state_next;

   // a zero step would freeze the output, so it moves one lsb minimum
   always_comb begin
      state_next = state_reg;
      if (state_reg.tick == RAMP_TICK_CYCLES - 8'h01) begin
         state_next.tick = 8'h00;
         if (request > state_reg.level) begin
            if (request - state_reg.level <= stepPerTick) begin
               state_next.level = request;
            end else begin
               state_next.level = state_reg.level +
                  ((stepPerTick == 16'h0000) ? 16'h0001 : stepPerTick);
            end
         end else if (request < state_reg.level) begin
            if (state_reg.level - request <= stepPerTick) begin
               state_next.level = request;
            end else begin
               state_next.level = state_reg.level -
                  ((stepPerTick == 16'h0000) ? 16'h0001 : stepPerTick);
            end
         end
      end else begin
         state_next.tick = state_reg.tick + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign refOut = state_reg.level;
endmodule : pmva_ramp
`default_nettype wire

// ---- pmva_vout_alert_regs.sv ----
// pmva_vout_alert_regs.sv: alert masks, vout format and vout target bank
`default_nettype none
module pmva_vout_alert_regs
   import pmva_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   input  wire pmva_cmd_type cmdReq,
   output pmva_rsp_type      cmdRsp,
   input  wire logic         convEnable,
   input  wire logic         powerGoodResetPin_n,
   input  wire logic         pgResetModeEn,
   input  wire logic         faultBootRestoreSel,
   input  wire logic         pinStrapOverride,
   input  wire logic [15:0]  voltageSelectCode,
   input  wire logic [15:0]  nvmTarget,
   input  wire logic [7:0]   nvmVendorMask,
   input  wire logic [7:0]   nvmFormat,
   input  wire logic         restoreUserAll,
   input  wire logic         faultHiccup,
   input  wire logic [15:0]  voutTrim,
   input  wire logic [15:0]  voutMax,
   input  wire logic [15:0]  voutMin,
   input  wire logic [15:0]  transitionStep,
   input  wire logic [7:0]   statusVendor,
   input  wire logic         clearStatus,
   output logic              alertOut,
   output logic [15:0]       vrefOut,
   output logic [7:0]        formatOut,
   output logic              statusWordVout,
   output logic              statusVoutLimit
);
   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]   vendorMask;
      logic [7:0]   format;
      logic [15:0]  target;
      logic [15:0]  boot;
      logic         loadPend;
      logic         pinSync1;
      logic         pinSync2;
      logic         wordVout;
      logic         voutLimit;
      logic         alert;
      pmva_rsp_type rsp;
   } pmva_regs_type;

   pmva_regs_type state_reg;
   pmva_regs_type state_next;

   logic        limitHit;
   logic [15:0] refRequest;
   logic [15:0] defaultTarget;
   logic [7:0]  newFormat;
   logic        isWr;
   logic        isRd;

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      state_next    = state_reg;
      isWr          = cmdReq.valid && cmdReq.write;
      isRd          = cmdReq.valid && !cmdReq.write;
      newFormat     = (cmdReq.data[7:0] & FMT_WR_MASK) |
                      {1'b0, FMT_MODE_LINEAR, 5'h00};
      defaultTarget = pinStrapOverride ? voltageSelectCode : nvmTarget;

      // pin passes two flops before anything looks at it
      state_next.pinSync1 = powerGoodResetPin_n;
      state_next.pinSync2 = state_reg.pinSync1;

      state_next.rsp.valid = 1'b0;
      state_next.rsp.err   = 1'b0;

      // host access; a later branch below overrides the target
      if (isWr) begin
         case (cmdReq.code)
            CMD_ALERT_MASK: begin
               // low byte names the group, high byte carries the mask
               if (cmdReq.data[7:0] == SEL_VENDOR_GRP) begin
                  state_next.vendorMask =
                     cmdReq.data[15:8] & MASK_VENDOR_WR;
               end else if (cmdReq.data[7:0] != SEL_MISC_GROUP) begin
                  state_next.rsp.valid = 1'b1;
                  state_next.rsp.err   = 1'b1;
               end
            end
            CMD_VOUT_FORMAT: begin
               if (convEnable ||
                   !pmva_exp_ok(newFormat[FMT_EXP_MSB:0])) begin
                  state_next.rsp.valid = 1'b1;
                  state_next.rsp.err   = 1'b1;
               end else begin
                  state_next.format = newFormat;
                  state_next.target = pmva_rescale(state_reg.target,
                     state_reg.format[FMT_EXP_MSB:0],
                     newFormat[FMT_EXP_MSB:0]);
                  state_next.boot = pmva_rescale(state_reg.boot,
                     state_reg.format[FMT_EXP_MSB:0],
                     newFormat[FMT_EXP_MSB:0]);
               end
            end
            CMD_VOUT_TARGET: begin
               state_next.target = cmdReq.data;
            end
            default: begin
               state_next.rsp.valid = 1'b1;
               state_next.rsp.err   = 1'b1;
            end
         endcase
      end else if (isRd) begin
         state_next.rsp.valid = 1'b1;
         state_next.rsp.data  = 16'h0000;
         case (cmdReq.code)
            CMD_ALERT_MASK: begin
               if (cmdReq.data[7:0] == SEL_MISC_GROUP) begin
                  state_next.rsp.data = {8'h00, MASK_MISC_VALUE};
               end else if (cmdReq.data[7:0] == SEL_VENDOR_GRP) begin
                  state_next.rsp.data = {8'h00, state_reg.vendorMask};
               end else begin
                  state_next.rsp.err = 1'b1;
               end
            end
            CMD_VOUT_FORMAT: begin
               state_next.rsp.data = {8'h00, state_reg.format};
            end
            CMD_VOUT_TARGET: begin
               state_next.rsp.data = state_reg.target;
            end
            default: begin
               state_next.rsp.err = 1'b1;
            end
         endcase
      end

      // fault hiccup: keep or revert to the stored boot value
      if (faultHiccup && faultBootRestoreSel) begin
         state_next.target = state_reg.boot;
      end

      // reset pin holds the target at boot while asserted
      if (pgResetModeEn && !state_reg.pinSync2) begin
         state_next.target = state_reg.boot;
      end

      // defaults land on the first enabled edge after reset, or on restore
      if (state_reg.loadPend || restoreUserAll) begin
         state_next.loadPend   = 1'b0;
         state_next.boot       = defaultTarget;
         state_next.target     = defaultTarget;
         state_next.vendorMask = nvmVendorMask & MASK_VENDOR_WR;
         state_next.format     = (nvmFormat & FMT_WR_MASK) |
                                 {1'b0, FMT_MODE_LINEAR, 5'h00};
      end

      // limit warning flags: a set in the clear cycle wins
      if (clearStatus) begin
         state_next.wordVout  = 1'b0;
         state_next.voutLimit = 1'b0;
      end
      if (limitHit) begin
         state_next.wordVout  = 1'b1;
         state_next.voutLimit = 1'b1;
      end

      // sync mask left clear may pulse the alert on a stack enable
      state_next.alert =
         (|(statusVendor & ~state_reg.vendorMask & MASK_VENDOR_WR)) ||
         state_reg.voutLimit;
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg            <= '0;
         state_reg.vendorMask <= MASK_VENDOR_RESET;
         state_reg.format     <= FMT_RESET;
         state_reg.target     <= TARGET_RESET;
         state_reg.boot       <= TARGET_RESET;
         state_reg.loadPend   <= 1'b1;
         state_reg.pinSync1   <= 1'b1;
         state_reg.pinSync2   <= 1'b1;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------------
   // reference path
   // -------------------------------------------------------------------
   pmva_limit_clamp clampInst (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .ce         (ce),
      .target     (state_reg.target),
      .trim       (voutTrim),
      .limitMax   (voutMax),
      .limitMin   (voutMin),
      .refRequest (refRequest),
      .limitHit   (limitHit)
   );

   pmva_ramp rampInst (
      .ref_clk     (ref_clk),
      .nrst        (nrst),
      .ce          (ce),
      .request     (refRequest),
      .stepPerTick (transitionStep),
      .refOut      (vrefOut)
   );

   assign cmdRsp          = state_reg.rsp;
   assign alertOut        = state_reg.alert;
   assign formatOut       = state_reg.format;
   assign statusWordVout  = state_reg.wordVout;
   assign statusVoutLimit = state_reg.voutLimit;
endmodule : pmva_vout_alert_regs
`default_nettype wire

// ---- pmva_vout_alert_regs_sva.sv ----
// pmva_vout_alert_regs_sva.sv: port checker for the vout/alert bank
`default_nettype none
module pmva_vout_alert_regs_sva
   import pmva_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         nrst,
   input wire logic         ce,
   input wire pmva_cmd_type cmdReq,
   input wire pmva_rsp_type cmdRsp,
   input wire logic         convEnable,
   input wire logic         restoreUserAll,
   input wire logic [15:0]  voutMax,
   input wire logic [15:0]  transitionStep,
   input wire logic         alertOut,
   input wire logic [15:0]  vrefOut,
   input wire logic [7:0]   formatOut,
   input wire logic         statusWordVout,
   input wire logic         statusVoutLimit
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // the first edges after reset load defaults, so some checks wait
   logic [1:0] upReg;
   logic [1:0] upNext;
   logic       takeReq;
   logic       isRead;

   always_comb upNext = (upReg == 2'h3) ? upReg : upReg + 2'h1;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) upReg <= 2'h0;
      else upReg <= upNext;
   end
   assign takeReq = ce && cmdReq.valid;
   assign isRead  = takeReq && !cmdReq.write;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   fmt_mode_zero_a : assert property (formatOut[6:5] == 2'h0)
      else $error("format mode field not linear");
   fmt_exp_range_a : assert property ($signed(formatOut[4:0]) >= -12 &&
      $signed(formatOut[4:0]) <= -4) else $error("format exponent out of range");
   fmt_locked_a : assert property (upReg == 2'h3 && ce && convEnable &&
      !restoreUserAll |=> $stable(formatOut)) else $error("format changed");
   rsp_cause_a : assert property (cmdRsp.valid |-> $past(takeReq))
      else $error("response without command");
   read_answer_a : assert property (isRead |=> cmdRsp.valid)
      else $error("read got no response");
   misc_read_a : assert property (isRead && cmdReq.code == CMD_ALERT_MASK &&
      cmdReq.data[7:0] == SEL_MISC_GROUP |=> !cmdRsp.err &&
      cmdRsp.data[7:0] == MASK_MISC_VALUE) else $error("misc mask bad");
   vendor_read_a : assert property (isRead &&
      cmdReq.code == CMD_ALERT_MASK && cmdReq.data[7:0] == SEL_VENDOR_GRP
      |=> (cmdRsp.data[7:0] & ~MASK_VENDOR_WR) == 8'h00)
      else $error("vendor mask reserved bits set");
   fmt_refuse_a : assert property (takeReq && cmdReq.write &&
      cmdReq.code == CMD_VOUT_FORMAT && convEnable
      |=> cmdRsp.valid && cmdRsp.err) else $error("format write not refused");
   limit_alert_a : assert property (ce && statusVoutLimit |=> alertOut)
      else $error("limit flag without alert");
   limit_word_a : assert property ($rose(statusVoutLimit) |-> statusWordVout)
      else $error("status word flag missing");
   vref_max_a : assert property (upReg == 2'h3 |-> vrefOut <= voutMax)
      else $error("reference above maximum");
   ramp_hold_a : assert property ($changed(vrefOut) |=> $stable(vrefOut)[*8])
      else $error("reference moved too often");
   ramp_step_a : assert property ($changed(vrefOut) |->
      ((vrefOut > $past(vrefOut)) ? vrefOut - $past(vrefOut)
      : $past(vrefOut) - vrefOut) <=
      ((transitionStep == 16'h0000) ? 16'h0001 : transitionStep))
      else $error("reference step too large");
endmodule : pmva_vout_alert_regs_sva

bind pmva_vout_alert_regs pmva_vout_alert_regs_sva u_sva (.ref_clk, .nrst,
   .ce, .cmdReq, .cmdRsp, .convEnable, .restoreUserAll, .voutMax,
   .transitionStep, .alertOut, .vrefOut, .formatOut, .statusWordVout,
   .statusVoutLimit);
`default_nettype wire

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench for the vout/alert register bank
`default_nettype none
module tb_top
   import pmva_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        err;
      logic [15:0] keep;
      logic [15:0] data;
   } pmva_note_type;

   logic         ref_clk = 1'b0;
   logic         nrst, ce, convEnable, powerGoodResetPin_n, pgResetModeEn;
   logic         faultBootRestoreSel, pinStrapOverride, restoreUserAll;
   logic         faultHiccup, clearStatus, alertOut;
   logic         statusWordVout, statusVoutLimit;
   logic [15:0]  voltageSelectCode, nvmTarget, voutTrim, voutMax, voutMin;
   logic [15:0]  transitionStep, vrefOut, tgt, rampExp;
   logic [7:0]   nvmVendorMask, nvmFormat, statusVendor, formatOut, v;
   pmva_cmd_type cmdReq;
   pmva_rsp_type cmdRsp;
   pmva_note_type note;
   pmva_note_type noteQ[$];
   int           error_cnt = 0;
   int           n_compared = 0;

   always #2 ref_clk = ~ref_clk;

   pmva_vout_alert_regs u_dut (.ref_clk, .nrst, .ce, .cmdReq, .cmdRsp,
      .convEnable, .powerGoodResetPin_n, .pgResetModeEn, .faultBootRestoreSel,
      .pinStrapOverride, .voltageSelectCode, .nvmTarget, .nvmVendorMask,
      .nvmFormat, .restoreUserAll, .faultHiccup, .voutTrim, .voutMax,
      .voutMin, .transitionStep, .statusVendor, .clearStatus, .alertOut,
      .vrefOut, .formatOut, .statusWordVout, .statusVoutLimit);
   pmva_host_model u_host (.ref_clk, .cmdReq);

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // reads and refused writes leave a note; accepted writes answer nothing
   task automatic cmd(input logic wr, input logic [7:0] code,
      input logic [15:0] data, input logic err, input logic [15:0] exp);
      if (!wr || err) noteQ.push_back('{err, (err ? 16'h0 : 16'hFFFF), exp});
      u_host.send(wr, code, data);
   endtask : cmd

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results

   // ------------------------------------------------------------------
   // response monitor
   // ------------------------------------------------------------------
   // responses are looked at on the falling edge, once they have settled
   always @(negedge ref_clk) begin
      if (nrst === 1'b1 && cmdRsp.valid !== 1'b0) begin
         if (noteQ.size() == 0) check("response count", 16'h0, 16'h1);
         else begin
            note = noteQ.pop_front();
            check("response err", 16'(note.err), 16'(cmdRsp.err));
            check("response data", note.data, cmdRsp.data & note.keep);
         end
      end
   end

   initial begin
      #80000;
      error_cnt++;
      results();
   end

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'hCFA79BD0));
      nrst = 1'b0;
      ce = 1'b1;
      convEnable = 1'b0;
      powerGoodResetPin_n = 1'b1;
      pgResetModeEn = 1'b0;
      faultBootRestoreSel = 1'b0;
      pinStrapOverride = 1'b0;
      restoreUserAll = 1'b0;
      faultHiccup = 1'b0;
      clearStatus = 1'b0;
      statusVendor = 8'h00;
      voutMin = 16'h0000;
      voutMax = 16'hF000;
      voutTrim = 16'($urandom_range(15));
      transitionStep = 16'($urandom_range(16'h0100, 16'h0010));
      nvmTarget = 16'($urandom_range(16'h0FFF, 16'h0100));
      voltageSelectCode = 16'($urandom_range(16'h0FFF, 16'h0100));
      nvmVendorMask = 8'($urandom);
      nvmFormat = 8'h14;
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      cmd(0, CMD_VOUT_TARGET, 16'h0, 0, nvmTarget);
      cmd(0, CMD_ALERT_MASK, 16'h007E, 1, 16'h0);
      cmd(0, 8'h22, 16'h0, 1, 16'h0);
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? nvmVendorMask : (i == 1) ? 8'hFF : 8'($urandom);
         if (i > 0) cmd(1, CMD_ALERT_MASK, {v, SEL_VENDOR_GRP}, 0, 16'h0);
         cmd(1, CMD_ALERT_MASK, {v, SEL_MISC_GROUP}, 0, 16'h0);
         cmd(0, CMD_ALERT_MASK, 16'(SEL_VENDOR_GRP), 0, 16'(v & 8'hCE));
         cmd(0, CMD_ALERT_MASK, 16'(SEL_MISC_GROUP), 0, 16'h0001);
      end
      cmd(1, CMD_ALERT_MASK, {8'h00, SEL_VENDOR_GRP}, 0, 16'h0);
      statusVendor = 8'h02;
      repeat (3) @(negedge ref_clk);
      check("alert unmasked", 16'h1, 16'(alertOut));
      cmd(1, CMD_ALERT_MASK, {8'h02, SEL_VENDOR_GRP}, 0, 16'h0);
      repeat (3) @(negedge ref_clk);
      check("alert masked", 16'h0, 16'(alertOut));
      statusVendor = 8'h00;
      tgt = 16'($urandom) & 16'h0FF0;
      cmd(1, CMD_VOUT_TARGET, tgt, 0, 16'h0);
      cmd(0, CMD_VOUT_TARGET, 16'h0, 0, tgt);
      convEnable = 1'b1;
      cmd(1, CMD_VOUT_FORMAT, 16'h0018, 1, 16'h0);
      convEnable = 1'b0;
      cmd(0, CMD_VOUT_FORMAT, 16'h0, 0, 16'h0014);
      cmd(1, CMD_VOUT_FORMAT, 16'h001D, 1, 16'h0);
      cmd(1, CMD_VOUT_FORMAT, 16'h0013, 1, 16'h0);
      cmd(1, CMD_VOUT_FORMAT, 16'h00F8, 0, 16'h0);
      cmd(0, CMD_VOUT_FORMAT, 16'h0, 0, 16'h0098);
      check("format out", 16'h0098, 16'(formatOut));
      cmd(0, CMD_VOUT_TARGET, 16'h0, 0, tgt >> 4);
      cmd(1, CMD_VOUT_TARGET, 16'h0123, 0, 16'h0);
      cmd(1, CMD_VOUT_FORMAT, 16'h0014, 0, 16'h0);
      cmd(0, CMD_VOUT_TARGET, 16'h0, 0, 16'h1230);
      // boot value went through the same rescale, so low bits are lost
      pgResetModeEn = 1'b1;
      powerGoodResetPin_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      cmd(0, CMD_VOUT_TARGET, 16'h0, 0, nvmTarget & 16'hFFF0);
      powerGoodResetPin_n = 1'b1;
      repeat (5) @(negedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         faultBootRestoreSel = i[0];
         cmd(1, CMD_VOUT_TARGET, tgt, 0, 16'h0);
         faultHiccup = 1'b1;
         @(negedge ref_clk);
         faultHiccup = 1'b0;
         cmd(0, CMD_VOUT_TARGET, 16'h0, 0,
             (i == 1) ? (nvmTarget & 16'hFFF0) : tgt);
      end
      cmd(1, CMD_VOUT_TARGET, 16'hF800, 0, 16'h0);
      repeat (4) @(negedge ref_clk);
      check("limit flag", 16'h1, 16'(statusVoutLimit));
      check("status word", 16'h1, 16'(statusWordVout));
      check("limit alert", 16'h1, 16'(alertOut));
      cmd(1, CMD_VOUT_TARGET, tgt, 0, 16'h0);
      repeat (3) @(negedge ref_clk);
      clearStatus = 1'b1;
      @(negedge ref_clk);
      clearStatus = 1'b0;
      repeat (3) @(negedge ref_clk);
      check("limit cleared", 16'h0, 16'(statusVoutLimit));
      check("alert cleared", 16'h0, 16'(alertOut));
      pinStrapOverride = 1'b1;
      restoreUserAll = 1'b1;
      @(negedge ref_clk);
      restoreUserAll = 1'b0;
      repeat (2) @(negedge ref_clk);
      cmd(0, CMD_VOUT_TARGET, 16'h0, 0, voltageSelectCode);
      cmd(0, CMD_VOUT_FORMAT, 16'h0, 0, 16'h0014);
      repeat (4) @(negedge ref_clk);
      // one tick window holds exactly one ramp step toward target plus trim
      rampExp = voltageSelectCode + voutTrim;
      tgt = vrefOut + transitionStep;
      if (tgt < rampExp) rampExp = tgt;
      repeat (250) @(negedge ref_clk);
      check("ramp step", rampExp, vrefOut);
      check("pending responses", 16'h0, 16'(noteQ.size()));
      results();
   end
endmodule : tb_top
`default_nettype wire
